// ### rpm_cfg.svh
// Notes on behaviour
// - Any reset source asserts internal reset, timer-gated
// - Software reset request resets whole device
// - After reset, processor fetches from address zero
// - Registers hold defined values at reset release
// - Power-on and brownout reset hold reset low-supply
// - Release comes 100 us after brownout reset ends
// - Brownout level raises interrupt; status always readable
// - Fixed brownout trip forces reset regardless software
// - Internal RC oscillator is default clock source
// - Reset timer starts at threshold, release after count
// - Without external reset, boot starts at timer expiry
// - With external reset, boot waits pin deassert too
// - Bit 15 powers down temperature sensor, resets one
// - Read-only family code register ignores writes
// - Read-only variant code register identifies product
// - Gate register gates clocks; divider sets frequency
// - Peripheral dividers; zero setting stops that clock
// - Wait-for-interrupt without deep-sleep stops core clock
// - Interrupt or reset wakes processor from sleep
// - Sleep keeps enabled peripherals and state running
`ifndef RPM_CFG_SVH
`define RPM_CFG_SVH

// ****************************************************
// timing
// ****************************************************
`define CLK_PERIOD_NS    20
`define RST_HOLD_US      100
`define RST_HOLD_CYCLES  ((`RST_HOLD_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_CNT_W        16

// ****************************************************
// register byte addresses
// ****************************************************
`define ADDR_CLK_SEL     32'h4004_8070
`define ADDR_SYS_DIV     32'h4004_8078
`define ADDR_CLK_GATE    32'h4004_8080
`define ADDR_UART_DIV    32'h4004_8098
`define ADDR_TICK_DIV    32'h4004_80B0
`define ADDR_WDT_DIV     32'h4004_80D8
`define ADDR_BOD_CTRL    32'h4004_8150
`define ADDR_BOD_STAT    32'h4004_8154
`define ADDR_APD         32'h4004_8238
`define ADDR_FAMILY      32'h4004_83F4
`define ADDR_VARIANT     32'h4004_83FC

// ****************************************************
// fields and reset values
// ****************************************************
`define APD_W            17
`define APD_TS_BIT       15
`define APD_RST          17'h1_EDF8
`define CLKSEL_IRC       2'h0
`define SYS_DIV_RST      8'h01
`define PER_DIV_RST      8'h00
`define CLK_GATE_RST     32'h0000_001F
`define HSIZE_WORD       3'h2
`define FAMILY_CODE_DFLT  32'h1234_0001
`define VARIANT_CODE_DFLT 32'h0000_0A5A

`endif

// ### rpm_pkg.sv
package rpm_pkg;
  // processor power state
  typedef enum logic {ST_RUN, ST_SLEEP} pwr_state_type;
  // register selected by an address
  typedef enum logic [3:0] {
    REG_NONE, REG_CLK_SEL, REG_SYS_DIV, REG_CLK_GATE, REG_UART_DIV, REG_TICK_DIV,
    REG_WDT_DIV, REG_BOD_CTRL, REG_BOD_STAT, REG_APD, REG_FAMILY, REG_VARIANT
  } reg_sel_type;
endpackage : rpm_pkg

// ### reset_delay_timer.sv
`timescale 1ns/1ps
`include "rpm_cfg.svh"
module reset_delay_timer #(
  parameter int unsigned HOLD_CYCLES = `RST_HOLD_CYCLES
) (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  // control
  input  wire logic i_clear,
  output logic      o_done
);
  logic [`RST_CNT_W-1:0] cnt_r;
  localparam logic [`RST_CNT_W-1:0] HOLD = HOLD_CYCLES[`RST_CNT_W-1:0];

  // ****************************************************
  // count from the end of the hold sources
  // ****************************************************
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_r <= '0;
    end else if (i_clear) begin
      cnt_r <= '0;
    end else if (cnt_r != HOLD) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign o_done = (cnt_r == HOLD);

  // helper: cycles seen since clear dropped
  logic [`RST_CNT_W:0] quiet_r;
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      quiet_r <= '0;
    end else if (i_clear) begin
      quiet_r <= '0;
    end else if (!quiet_r[`RST_CNT_W]) begin
      quiet_r <= quiet_r + 1'b1;
    end
  end

  property p_hold_min;
    @(posedge i_clk_sys) disable iff (i_sys_rst) o_done |-> quiet_r >= {1'b0, HOLD};
  endproperty
  a_hold_min: assert property (p_hold_min) else $error("timer done too early");

  property p_hold_max;
    @(posedge i_clk_sys) disable iff (i_sys_rst) (quiet_r == {1'b0, HOLD}) |-> o_done;
  endproperty
  a_hold_max: assert property (p_hold_max) else $error("timer done too late");
endmodule : reset_delay_timer

// ### clk_tick_divider.sv
`timescale 1ns/1ps
module clk_tick_divider (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  // divide setting, zero stops
  input  wire logic [7:0] i_div,
  output logic            o_tick
);
  logic [7:0] cnt_r;

  // ****************************************************
  // divide counter and tick flop
  // ****************************************************
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_r  <= 8'h00;
      o_tick <= 1'b0;
    end else if (i_div == 8'h00) begin
      cnt_r  <= 8'h00;
      o_tick <= 1'b0;
    end else if (cnt_r >= i_div - 8'h01) begin
      cnt_r  <= 8'h00;
      o_tick <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 8'h01;
      o_tick <= 1'b0;
    end
  end

  property p_div_off;
    @(posedge i_clk_sys) disable iff (i_sys_rst) (i_div == 8'h00) |=> !o_tick;
  endproperty
  a_div_off: assert property (p_div_off) else $error("tick while divider off");
endmodule : clk_tick_divider

// ### reset_power_ctrl.sv
`timescale 1ns/1ps
`include "rpm_cfg.svh"
module reset_power_ctrl #(
  parameter int unsigned HOLD_CYCLES  = `RST_HOLD_CYCLES,
  parameter logic [31:0] FAMILY_CODE  = `FAMILY_CODE_DFLT,  // arbitrary value
  parameter logic [31:0] VARIANT_CODE = `VARIANT_CODE_DFLT  // arbitrary value
) (
  // clock and reset
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_sys_rst,
  // reset sources
  input  wire logic                  i_por_active,
  input  wire logic                  i_bod_reset_trip,
  input  wire logic                  i_wdt_reset,
  input  wire logic                  i_system_reset_request,
  input  wire logic                  i_ext_reset_n,
  // brownout level monitor
  input  wire logic                  i_bod_below_level,
  // processor sleep signals
  input  wire logic                  i_deep_sleep_select,
  input  wire logic                  i_wait_for_interrupt_instr,
  input  wire logic                  i_irq_pending,
  // ahb-lite slave
  input  wire logic                  i_hsel,
  input  wire logic [31:0]           i_haddr,
  input  wire logic [1:0]            i_htrans,
  input  wire logic                  i_hwrite,
  input  wire logic [2:0]            i_hsize,
  input  wire logic [31:0]           i_hwdata,
  input  wire logic                  i_hready,
  output logic      [31:0]           o_hrdata,
  output logic                       o_hreadyout,
  output logic                       o_hresp,
  // reset outputs
  output logic                       o_int_reset,
  output logic                       o_boot_start,
  output logic      [31:0]           o_start_addr,
  // clock control
  output logic      [1:0]            o_main_clk_sel,
  output logic                       o_core_clk_en,
  output logic      [31:0]           o_bus_clk_gate,
  output logic      [3:0]            o_clk_tick,
  // power control
  output logic      [`APD_W-1:0]     o_analog_power_config,
  output logic                       o_temp_sensor_powerdown,
  output logic                       o_bod_irq,
  output rpm_pkg::pwr_state_type     o_power_state
);
  import rpm_pkg::*;

  // ****************************************************
  // address decode
  // ****************************************************
  function automatic reg_sel_type decode_addr(input logic [31:0] a);
    case (a)
      `ADDR_CLK_SEL:  decode_addr = REG_CLK_SEL;
      `ADDR_SYS_DIV:  decode_addr = REG_SYS_DIV;
      `ADDR_CLK_GATE: decode_addr = REG_CLK_GATE;
      `ADDR_UART_DIV: decode_addr = REG_UART_DIV;
      `ADDR_TICK_DIV: decode_addr = REG_TICK_DIV;
      `ADDR_WDT_DIV:  decode_addr = REG_WDT_DIV;
      `ADDR_BOD_CTRL: decode_addr = REG_BOD_CTRL;
      `ADDR_BOD_STAT: decode_addr = REG_BOD_STAT;
      `ADDR_APD:      decode_addr = REG_APD;
      `ADDR_FAMILY:   decode_addr = REG_FAMILY;
      `ADDR_VARIANT:  decode_addr = REG_VARIANT;
      default:        decode_addr = REG_NONE;
    endcase
  endfunction : decode_addr

  // ****************************************************
  // reset sequencing
  // ****************************************************
  logic        hard_src;
  logic        timer_done;
  logic        int_rst_r;
  logic        int_rst_nxt;

  // sources that restart the release timer
  assign hard_src = i_por_active | i_bod_reset_trip | i_wdt_reset
                  | i_system_reset_request;

  reset_delay_timer #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_rst_timer (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_clear   (hard_src),
    .o_done    (timer_done)
  );

  // release needs timer expiry and the pin high
  assign int_rst_nxt = hard_src | ~timer_done | ~i_ext_reset_n;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      int_rst_r <= 1'b1;
    end else begin
      int_rst_r <= int_rst_nxt;
    end
  end

  assign o_int_reset  = int_rst_r;
  assign o_boot_start = ~int_rst_r;

  // fetch address presented at release
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_start_addr <= 32'h0000_0000;
    end else if (int_rst_r) begin
      o_start_addr <= 32'h0000_0000;
    end
  end

  // ****************************************************
  // bus slave
  // ****************************************************
  logic        addr_hit;
  logic        wr_pend_r;
  logic [31:0] wr_addr_r;
  logic        wr_en;
  reg_sel_type wr_sel;
  reg_sel_type rd_sel;

  assign addr_hit    = i_hsel & i_htrans[1] & i_hready;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign wr_en       = wr_pend_r & i_hready;
  assign wr_sel      = decode_addr(wr_addr_r);
  assign rd_sel      = decode_addr(i_haddr);

  // write address phase capture
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h0000_0000;
    end else if (i_hready) begin
      wr_pend_r <= addr_hit & i_hwrite & (i_hsize == `HSIZE_WORD);
      wr_addr_r <= i_haddr;
    end
  end

  // ****************************************************
  // software registers
  // ****************************************************
  logic [1:0]        clk_sel_r;
  logic [31:0]       clk_gate_r;
  logic [7:0]        div_r [4];
  logic              bod_irq_en_r;
  logic [`APD_W-1:0] apd_r;

  // plain control registers, defaults while in reset
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      clk_sel_r    <= `CLKSEL_IRC;
      clk_gate_r   <= `CLK_GATE_RST;
      bod_irq_en_r <= 1'b0;
      apd_r        <= `APD_RST;
    end else if (int_rst_r) begin
      clk_sel_r    <= `CLKSEL_IRC;
      clk_gate_r   <= `CLK_GATE_RST;
      bod_irq_en_r <= 1'b0;
      apd_r        <= `APD_RST;
    end else if (wr_en) begin
      unique case (wr_sel)
        REG_CLK_SEL:  clk_sel_r    <= i_hwdata[1:0];
        REG_CLK_GATE: clk_gate_r   <= i_hwdata;
        REG_BOD_CTRL: bod_irq_en_r <= i_hwdata[0];
        REG_APD:      apd_r        <= i_hwdata[`APD_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // divider settings: system, uart, systick, watchdog
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_r[0] <= `SYS_DIV_RST;
      div_r[1] <= `PER_DIV_RST;
      div_r[2] <= `PER_DIV_RST;
      div_r[3] <= `PER_DIV_RST;
    end else if (int_rst_r) begin
      div_r[0] <= `SYS_DIV_RST;
      div_r[1] <= `PER_DIV_RST;
      div_r[2] <= `PER_DIV_RST;
      div_r[3] <= `PER_DIV_RST;
    end else if (wr_en) begin
      unique case (wr_sel)
        REG_SYS_DIV:  div_r[0] <= i_hwdata[7:0];
        REG_UART_DIV: div_r[1] <= i_hwdata[7:0];
        REG_TICK_DIV: div_r[2] <= i_hwdata[7:0];
        REG_WDT_DIV:  div_r[3] <= i_hwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // read data registered in the address phase; id registers never written
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_hrdata <= 32'h0000_0000;
    end else if (addr_hit & ~i_hwrite) begin
      unique case (rd_sel)
        REG_CLK_SEL:  o_hrdata <= {30'h0, clk_sel_r};
        REG_SYS_DIV:  o_hrdata <= {24'h0, div_r[0]};
        REG_CLK_GATE: o_hrdata <= clk_gate_r;
        REG_UART_DIV: o_hrdata <= {24'h0, div_r[1]};
        REG_TICK_DIV: o_hrdata <= {24'h0, div_r[2]};
        REG_WDT_DIV:  o_hrdata <= {24'h0, div_r[3]};
        REG_BOD_CTRL: o_hrdata <= {31'h0, bod_irq_en_r};
        REG_BOD_STAT: o_hrdata <= {30'h0, o_bod_irq, i_bod_below_level};
        REG_APD:      o_hrdata <= {15'h0, apd_r};
        REG_FAMILY:   o_hrdata <= FAMILY_CODE;
        REG_VARIANT:  o_hrdata <= VARIANT_CODE;
        REG_NONE:     o_hrdata <= 32'h0000_0000;
      endcase
    end
  end

  assign o_main_clk_sel          = clk_sel_r;
  assign o_bus_clk_gate          = clk_gate_r;
  assign o_analog_power_config   = apd_r;
  assign o_temp_sensor_powerdown = apd_r[`APD_TS_BIT];

  // ****************************************************
  // clock dividers
  // ****************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_div
      clk_tick_divider u_div (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_div     (div_r[g]),
        .o_tick    (o_clk_tick[g])
      );
    end
  endgenerate

  // ****************************************************
  // brownout interrupt
  // ****************************************************
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_bod_irq <= 1'b0;
    end else begin
      o_bod_irq <= i_bod_below_level & bod_irq_en_r & ~int_rst_r;
    end
  end

  // ****************************************************
  // sleep control
  // ****************************************************
  pwr_state_type state_r;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= ST_RUN;
    end else if (int_rst_r) begin
      state_r <= ST_RUN;
    end else begin
      unique case (state_r)
        ST_RUN: begin
          if (i_wait_for_interrupt_instr & ~i_deep_sleep_select) begin
            state_r <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (i_irq_pending) begin
            state_r <= ST_RUN;
          end
        end
      endcase
    end
  end

  // only the core clock stops; gates and dividers keep running
  assign o_core_clk_en = (state_r == ST_RUN);
  assign o_power_state = state_r;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  sequence s_sleep_entry;
    (state_r == ST_RUN) && !int_rst_r && i_wait_for_interrupt_instr && !i_deep_sleep_select;
  endsequence

  sequence s_wake;
    (state_r == ST_SLEEP) && !int_rst_r && i_irq_pending;
  endsequence

  property p_src_reset;
    (i_wdt_reset || !i_ext_reset_n) |=> o_int_reset && !o_boot_start;
  endproperty
  a_src_reset: assert property (p_src_reset) else $error("source did not reset");

  property p_sw_reset;
    i_system_reset_request |=> o_int_reset ##1 (apd_r == `APD_RST && clk_gate_r == `CLK_GATE_RST);
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset ignored");

  property p_start_addr;
    $fell(o_int_reset) |-> o_start_addr == 32'h0000_0000 && div_r[0] == `SYS_DIV_RST;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("bad state at release");

  property p_por_hold;
    i_por_active |=> o_int_reset [*2];
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("reset dropped below trip");

  property p_bod_hard;
    (i_bod_reset_trip && !bod_irq_en_r) |=> o_int_reset;
  endproperty
  a_bod_hard: assert property (p_bod_hard) else $error("brownout trip no reset");

  property p_bod_irq;
    (i_bod_below_level && bod_irq_en_r && !int_rst_r) |=> o_bod_irq;
  endproperty
  a_bod_irq: assert property (p_bod_irq) else $error("brownout irq missing");

  property p_irc_default;
    $fell(o_int_reset) |-> o_main_clk_sel == `CLKSEL_IRC && o_temp_sensor_powerdown;
  endproperty
  a_irc_default: assert property (p_irc_default) else $error("defaults wrong");

  property p_boot_gate;
    $rose(o_boot_start) |-> $past(timer_done && i_ext_reset_n && !hard_src);
  endproperty
  a_boot_gate: assert property (p_boot_gate) else $error("boot before release");

  property p_boot_prompt;
    (timer_done && i_ext_reset_n && !hard_src) |=> o_boot_start;
  endproperty
  a_boot_prompt: assert property (p_boot_prompt) else $error("boot delayed");

  property p_family_ro;
    (addr_hit && !i_hwrite && rd_sel == REG_FAMILY) |=> o_hrdata == FAMILY_CODE;
  endproperty
  a_family_ro: assert property (p_family_ro) else $error("family code wrong");

  property p_variant;
    (addr_hit && !i_hwrite && rd_sel == REG_VARIANT) |=> o_hrdata == VARIANT_CODE;
  endproperty
  a_variant: assert property (p_variant) else $error("variant code wrong");

  property p_gate_write;
    (wr_en && !int_rst_r && wr_sel == REG_CLK_GATE) |=> o_bus_clk_gate == $past(i_hwdata);
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("gate write lost");

  property p_sleep_entry;
    s_sleep_entry |=> !o_core_clk_en;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("core clock not stopped");

  property p_wake;
    s_wake |=> o_core_clk_en;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on interrupt");

  property p_sleep_keep;
    ((state_r == ST_SLEEP) && !wr_en && !int_rst_r) |=> $stable(o_bus_clk_gate);
  endproperty
  a_sleep_keep: assert property (p_sleep_keep) else $error("gates changed asleep");
endmodule : reset_power_ctrl

// ### reset_and_power_mode_control_test.sv
`timescale 1ns/1ps
`include "rpm_cfg.svh"
module reset_and_power_mode_control_test;
  import rpm_pkg::*;
  // ****************************************************
  // settings and signals
  // ****************************************************
  localparam int          HOLD = 20;
  localparam logic [31:0] FAM  = 32'h1111_2222; // arbitrary value
  localparam logic [31:0] VAR  = 32'h3333_4444; // arbitrary value
  logic        clk, rst, por, trip, wdt, swr, ext_n, below, deep, wait_instr, irq;
  logic        hsel, hwrite, hreadyout, hresp, int_rst, boot, core_en, bod_irq, temp_sensor_powerdown;
  logic [31:0] haddr, hwdata, hrdata, start_addr, gate, rd, m_apd;
  logic [1:0]  htrans, clk_sel;
  logic [2:0]  hsize;
  logic [3:0]  tick;
  logic [16:0] apd;
  pwr_state_type pstate;
  wire         hready = hreadyout;
  int          bad_count, check_count, cyc, n, cnt, dv;
  logic [31:0] div_addr [4] = '{`ADDR_SYS_DIV, `ADDR_UART_DIV, `ADDR_TICK_DIV, `ADDR_WDT_DIV};

  reset_power_ctrl #(.HOLD_CYCLES(HOLD), .FAMILY_CODE(FAM), .VARIANT_CODE(VAR)) DUT (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_por_active(por), .i_bod_reset_trip(trip),
    .i_wdt_reset(wdt), .i_system_reset_request(swr), .i_ext_reset_n(ext_n),
    .i_bod_below_level(below), .i_deep_sleep_select(deep),
    .i_wait_for_interrupt_instr(wait_instr), .i_irq_pending(irq), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
    .o_hresp(hresp), .o_int_reset(int_rst), .o_boot_start(boot), .o_start_addr(start_addr),
    .o_main_clk_sel(clk_sel), .o_core_clk_en(core_en), .o_bus_clk_gate(gate),
    .o_clk_tick(tick), .o_analog_power_config(apd), .o_temp_sensor_powerdown(temp_sensor_powerdown),
    .o_bod_irq(bod_irq), .o_power_state(pstate));

  // ****************************************************
  // clock and watchdog of the run
  // ****************************************************
  // free running system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  // ****************************************************
  // tasks
  // ****************************************************
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t word got %h exp %h", $time, got, exp);
    end
  endtask : chk_w
  task automatic chk_b(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t bit got %b exp %b", $time, got, exp);
    end
  endtask : chk_b
  // single word transfer, address phase then data phase
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= `HSIZE_WORD;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : ahb
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr_reg
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk_w(q, exp);
  endtask : rd_chk
  // count edges until internal reset drops
  task automatic wait_rel();
    while (int_rst !== 1'b0 && n < 1000) begin
      @(posedge clk);
      n++;
      #1;
    end
  endtask : wait_rel
  // one cycle pulse on a sleep control input, checked two edges later
  task automatic pulse_sleep(input logic sel, input logic exp_en);
    @(posedge clk);
    deep       <= sel;
    wait_instr <= 1'b1;
    @(posedge clk);
    wait_instr <= 1'b0;
    @(posedge clk);
    #1;
    chk_b(core_en, exp_en);
  endtask : pulse_sleep
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    {rst, por, trip, wdt, swr, below, deep, wait_instr, irq, hsel, hwrite} = '0;
    {haddr, hwdata, htrans, hsize, cyc, n, bad_count, check_count} = '0;
    ext_n = 1'b1;
    rst   = 1'b1;
    void'($urandom(32'h65468d3b));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wait_rel();
    chk_b(boot, 1'b1);
    chk_w(start_addr, 32'h0);
    chk_w({30'h0, clk_sel}, {30'h0, `CLKSEL_IRC});
    chk_w({15'h0, apd}, {15'h0, `APD_RST});
    chk_b(temp_sensor_powerdown, 1'b1);
    chk_w(gate, `CLK_GATE_RST);
    rd_chk(`ADDR_APD, {15'h0, `APD_RST});
    chk_b(hresp, 1'b0);
    chk_b(hreadyout, 1'b1);
    wr_reg(`ADDR_FAMILY, $urandom());
    rd_chk(`ADDR_FAMILY, FAM);
    rd_chk(`ADDR_VARIANT, VAR);
    rd_chk(32'h4004_8000, 32'h0);
    // each hard source, apd register back to its reset value at release
    for (int s = 0; s < 4; s++) begin
      m_apd = $urandom() & 32'h0000_ED7F;
      wr_reg(`ADDR_APD, m_apd);
      rd_chk(`ADDR_APD, m_apd);
      chk_b(temp_sensor_powerdown, m_apd[`APD_TS_BIT]);
      @(posedge clk);
      {por, trip, wdt, swr} <= 4'b1000 >> s;
      @(posedge clk);
      {por, trip, wdt, swr} <= 4'h0;
      n = 0;
      @(posedge clk);
      n = 1;
      #1;
      chk_b(int_rst, 1'b1);
      chk_b(boot, 1'b0);
      wait_rel();
      chk_w(n, HOLD + 1);
      rd_chk(`ADDR_APD, {15'h0, `APD_RST});
    end
    // external pin holds release past timer expiry
    @(posedge clk);
    ext_n <= 1'b0;
    wdt   <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    repeat (3 * HOLD) @(posedge clk);
    #1;
    chk_b(boot, 1'b0);
    @(posedge clk);
    ext_n <= 1'b1;
    n = 0;
    wait_rel();
    chk_b(n <= 3, 1'b1);
    // gate register and dividers
    m_apd = $urandom();
    wr_reg(`ADDR_CLK_GATE, m_apd);
    rd_chk(`ADDR_CLK_GATE, m_apd);
    chk_w(gate, m_apd);
    for (int b = 0; b < 4; b++) begin
      dv = $urandom_range(1, 8);
      wr_reg(div_addr[b], dv);
      rd_chk(div_addr[b], dv);
      repeat (2 * dv + 2) @(posedge clk);
      cnt = 0;
      repeat (8 * dv) begin
        @(posedge clk);
        #1;
        cnt += tick[b];
      end
      chk_w(cnt, 8);
      wr_reg(div_addr[b], 32'h0);
      repeat (3) @(posedge clk);
      cnt = 0;
      repeat (16) begin
        @(posedge clk);
        #1;
        cnt += tick[b];
      end
      chk_w(cnt, 0);
    end
    // brownout level, enabled and polled
    wr_reg(`ADDR_BOD_CTRL, 32'h1);
    @(posedge clk);
    below <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_b(bod_irq, 1'b1);
    rd_chk(`ADDR_BOD_STAT, 32'h3);
    wr_reg(`ADDR_BOD_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    chk_b(bod_irq, 1'b0);
    rd_chk(`ADDR_BOD_STAT, 32'h1);
    below <= 1'b0;
    // sleep entry, deep select blocks it, irq and reset wake
    pulse_sleep(1'b1, 1'b1);
    pulse_sleep(1'b0, 1'b0);
    chk_b(pstate, ST_SLEEP);
    wr_reg(`ADDR_CLK_GATE, 32'h0000_00A5);
    #1;
    chk_w(gate, 32'h0000_00A5);
    @(posedge clk);
    irq <= 1'b1;
    @(posedge clk);
    irq <= 1'b0;
    @(posedge clk);
    #1;
    chk_b(core_en, 1'b1);
    pulse_sleep(1'b0, 1'b0);
    @(posedge clk);
    swr <= 1'b1;
    @(posedge clk);
    swr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk_b(core_en, 1'b1);
    n = 0;
    wait_rel();
    finish_test();
  end
endmodule : reset_and_power_mode_control_test
